// *** calendar_alarm_access_unit.v ***
// day, month, century, year counters, bus-access freeze and alarm logic
// assumes a serial-bus front end that raises i_acc_active for a whole
// access and presents byte writes on i_wr_en/i_addr/i_wdata; the lower
// time counters step on o_count_step and answer with i_day_carry one
// cycle later when the hour counter wraps
//
// Functional notes
// RQ1: century bit toggles on year 99 to 00
// RQ2: month register holds bcd month, bit 7 century
// RQ3: year register holds two-digit bcd year
// RQ4: february gets 29 days when year divisible by 4
// RQ5: counters frozen while host access in progress
// RQ6: after access, apply at most one pending tick
// RQ7: host finishes each access within one second
// RQ8: host accesses all time registers in one go
// RQ9: host reads seven time bytes from pointer 02h
// RQ10: minute match register with active-low enable
// RQ11: hour match register with active-low enable
// RQ12: day match register with active-low enable
// RQ13: weekday match register with active-low enable
// RQ14: all enabled fields match sets alarm flag
// RQ15: disabled fields ignored in comparison
// RQ16: flag sticky, sets again only on new match
// RQ17: interrupt pin follows flag when allowed
// RQ18: flag register write is anded with flags
// RQ19: weekday encoded 0 to 6 in three bits
// RQ20: day, month, year roll over correctly
// RQ21: no enables means flag never set
`default_nettype none
`timescale 1ns/100ps
`include "cal_alarm_consts.vh"

module calendar_alarm_access_unit (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_tick_1hz,
  input wire i_acc_active,
  input wire i_wr_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_day_carry,
  input wire [6:0] i_cur_minute,
  input wire [5:0] i_cur_hour,
  input wire [2:0] i_cur_weekday,
  output reg [7:0] o_rdata,
  output reg o_count_step,
  output reg o_int_n
);

  // ****************************************
  // declarations
  // ****************************************
  // freeze, calendar and alarm state
  reg tick_pend_q;
  reg tick_pend_d;
  reg carry_pend_q;
  reg carry_pend_d;
  reg step_d;
  reg day_step;
  reg century_q;
  reg [7:0] min_match_q;
  reg [7:0] hour_match_q;
  reg [7:0] day_match_q;
  reg [7:0] wday_match_q;
  reg alarm_hit_flag_q;
  reg alarm_hit_flag_d;
  reg alarm_irq_allow_q;
  reg last_match_q;
  reg eval_1_q;
  reg eval_2_q;
  reg [7:0] days_in_month;
  reg [7:0] rdata_d;
  // enables, counter values and decode
  wire minute_match_off;
  wire hour_match_off;
  wire day_match_off;
  wire weekday_match_off;
  wire [7:0] day_val;
  wire [7:0] month_val;
  wire [7:0] year_val;
  wire day_wrap;
  wire month_wrap;
  wire year_wrap;
  wire wr_day;
  wire wr_month;
  wire wr_year;
  wire wr_flags;
  wire leap_year;
  // alarm compare terms
  wire min_hit;
  wire hour_hit;
  wire day_hit;
  wire wday_hit;
  wire any_enabled;
  wire all_match;
  wire match_now;

  // one-cycle write strobes, one each for the day, month, year and flag registers
  assign wr_day = i_wr_en && (i_addr == `OFS_DAY);
  assign wr_month = i_wr_en && (i_addr == `OFS_MONTH);
  assign wr_year = i_wr_en && (i_addr == `OFS_YEAR);
  assign wr_flags = i_wr_en && (i_addr == `OFS_FLAGS);

  // ****************************************
  // access freeze and pending tick
  // ****************************************
  // a tick during an access is held; a second one in the same access is lost
  // a tick that meets a released pending one steps now and stays pending
  always @* begin
    if (i_acc_active) begin
      step_d = 1'b0; // RQ5
      tick_pend_d = tick_pend_q | i_tick_1hz; // RQ6
    end else begin
      step_d = tick_pend_q | i_tick_1hz; // RQ6
      tick_pend_d = tick_pend_q & i_tick_1hz;
    end
  end

  // day carry from the lower counters is frozen the same way
  always @* begin
    if (i_acc_active) begin
      day_step = 1'b0; // RQ5
      carry_pend_d = carry_pend_q | i_day_carry;
    end else begin
      day_step = carry_pend_q | i_day_carry;
      carry_pend_d = carry_pend_q & i_day_carry;
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      tick_pend_q <= 1'b0;
      carry_pend_q <= 1'b0;
      o_count_step <= 1'b0;
    end else begin
      tick_pend_q <= tick_pend_d;
      carry_pend_q <= carry_pend_d;
      o_count_step <= step_d;
    end
  end

  // ****************************************
  // calendar counters
  // ****************************************
  // bcd year divisible by 4, year 00 included
  // odd tens digit: units 2 or 6; even tens digit: units 0, 4 or 8
  assign leap_year = year_val[4] ? (year_val[3:0] == 4'h2 || year_val[3:0] == 4'h6)
                                 : (year_val[3:0] == 4'h0 || year_val[3:0] == 4'h4 ||
                                    year_val[3:0] == 4'h8); // RQ4

  always @* begin
    case (month_val)
      `MON_FEB: days_in_month = leap_year ? `DAYS_29 : `DAYS_28; // RQ4
      `MON_APR: days_in_month = `DAYS_30; // RQ20
      `MON_JUN: days_in_month = `DAYS_30;
      `MON_SEP: days_in_month = `DAYS_30;
      `MON_NOV: days_in_month = `DAYS_30;
      default: days_in_month = `DAYS_31;
    endcase
  end

  // a write loads a counter and beats a step in the same cycle
  // day wraps after the month's last day, month after 12, year after 99
  bcd2_count #(
    .RST_VAL(`RST_DAY)
  ) u_day (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_step(day_step),
    .i_load(wr_day),
    .i_load_val({2'b00, i_wdata[`DAY_MSB:0]}),
    .i_first(`FIRST_DAY),
    .i_last(days_in_month),
    .o_val(day_val),
    .o_wrap(day_wrap)
  ); // RQ20

  bcd2_count #(
    .RST_VAL(`RST_MONTH)
  ) u_month (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_step(day_wrap),
    .i_load(wr_month),
    .i_load_val({3'b000, i_wdata[`MONTH_MSB:0]}),
    .i_first(`FIRST_MONTH),
    .i_last(`LAST_MONTH),
    .o_val(month_val),
    .o_wrap(month_wrap)
  ); // RQ2

  bcd2_count #(
    .RST_VAL(`RST_YEAR)
  ) u_year (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_step(month_wrap),
    .i_load(wr_year),
    .i_load_val(i_wdata),
    .i_first(`FIRST_YEAR),
    .i_last(`LAST_YEAR),
    .o_val(year_val),
    .o_wrap(year_wrap)
  ); // RQ3

  // ****************************************
  // century bit
  // ****************************************
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      century_q <= 1'b0;
    end else if (wr_month) begin
      // a month write beats a roll in the same cycle
      century_q <= i_wdata[`BIT_CENTURY];
    end else if (year_wrap) begin
      century_q <= ~century_q; // RQ1
    end
  end

  // ****************************************
  // match registers
  // ****************************************
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      min_match_q <= `RST_MATCH; // RQ10
      hour_match_q <= `RST_MATCH; // RQ11
      day_match_q <= `RST_MATCH; // RQ12
      wday_match_q <= `RST_MATCH; // RQ13
    end else if (i_wr_en) begin
      // unused bits stored as zero so they read back zero
      case (i_addr)
        `OFS_MIN_MATCH: min_match_q <= {i_wdata[`BIT_MATCH_OFF], i_wdata[`MIN_MSB:0]}; // RQ10
        `OFS_HOUR_MATCH: hour_match_q <= {i_wdata[`BIT_MATCH_OFF], 1'b0,
                                          i_wdata[`HOUR_MSB:0]}; // RQ11
        `OFS_DAY_MATCH: day_match_q <= {i_wdata[`BIT_MATCH_OFF], 1'b0,
                                        i_wdata[`DAY_MSB:0]}; // RQ12
        `OFS_WDAY_MATCH: wday_match_q <= {i_wdata[`BIT_MATCH_OFF], 4'h0,
                                          i_wdata[`WDAY_MSB:0]}; // RQ13
        default: begin
        end
      endcase
    end
  end

  assign minute_match_off = min_match_q[`BIT_MATCH_OFF];
  assign hour_match_off = hour_match_q[`BIT_MATCH_OFF];
  assign day_match_off = day_match_q[`BIT_MATCH_OFF];
  assign weekday_match_off = wday_match_q[`BIT_MATCH_OFF];

  // ****************************************
  // alarm comparison
  // ****************************************
  assign any_enabled = !(minute_match_off && hour_match_off &&
                         day_match_off && weekday_match_off); // RQ21
  // a disabled field counts as a hit and drops out of the compare
  assign min_hit = minute_match_off || (min_match_q[`MIN_MSB:0] == i_cur_minute); // RQ15
  assign hour_hit = hour_match_off || (hour_match_q[`HOUR_MSB:0] == i_cur_hour); // RQ15
  assign day_hit = day_match_off || (day_match_q[`DAY_MSB:0] == day_val[`DAY_MSB:0]); // RQ15
  assign wday_hit =
    weekday_match_off || (wday_match_q[`WDAY_MSB:0] == i_cur_weekday); // RQ15 RQ19
  assign all_match = min_hit && hour_hit && day_hit && wday_hit; // RQ14
  assign match_now = any_enabled && all_match; // RQ14

  // compare two cycles after a step, once lower counters and day settled
  // flag sets on the rise of a match only, so a match that holds
  // does not set it again after the host has cleared it
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      eval_1_q <= 1'b0;
      eval_2_q <= 1'b0;
      last_match_q <= 1'b0;
    end else begin
      eval_1_q <= o_count_step;
      eval_2_q <= eval_1_q;
      if (eval_2_q) begin
        last_match_q <= match_now;
      end
    end
  end

  // ****************************************
  // alarm flag and interrupt
  // ****************************************
  always @* begin
    alarm_hit_flag_d = alarm_hit_flag_q;
    if (wr_flags) begin
      alarm_hit_flag_d = alarm_hit_flag_q & i_wdata[`BIT_ALARM_FLAG]; // RQ18
    end
    // a set beats a clear written in the same cycle
    if (eval_2_q && match_now && !last_match_q) begin
      alarm_hit_flag_d = 1'b1; // RQ14 RQ16
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      alarm_hit_flag_q <= 1'b0;
      alarm_irq_allow_q <= 1'b0;
      o_int_n <= 1'b1;
    end else begin
      alarm_hit_flag_q <= alarm_hit_flag_d; // RQ16
      if (wr_flags) begin
        alarm_irq_allow_q <= i_wdata[`BIT_IRQ_ALLOW];
      end
      // pin follows the flag one cycle late while allowed
      o_int_n <= !(alarm_irq_allow_q && alarm_hit_flag_q); // RQ17
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always @* begin
    case (i_addr)
      // only the alarm bits live in the flag byte; the rest read zero
      `OFS_FLAGS: begin
        rdata_d = 8'h00;
        rdata_d[`BIT_ALARM_FLAG] = alarm_hit_flag_q;
        rdata_d[`BIT_IRQ_ALLOW] = alarm_irq_allow_q;
      end
      `OFS_DAY: rdata_d = day_val;
      `OFS_MONTH: rdata_d = {century_q, 2'b00, month_val[`MONTH_MSB:0]}; // RQ2
      `OFS_YEAR: rdata_d = year_val; // RQ3
      `OFS_MIN_MATCH: rdata_d = min_match_q;
      `OFS_HOUR_MATCH: rdata_d = hour_match_q;
      `OFS_DAY_MATCH: rdata_d = day_match_q;
      `OFS_WDAY_MATCH: rdata_d = wday_match_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      // answers the address of the previous cycle
      o_rdata <= rdata_d;
    end
  end

endmodule
`default_nettype wire

// *** cal_alarm_consts.vh ***
// constants for the calendar and alarm access unit
// assumes inclusion by bare name from the design files
`ifndef CAL_ALARM_CONSTS_VH
`define CAL_ALARM_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define OFS_FLAGS 8'h01
`define OFS_DAY 8'h05
`define OFS_MONTH 8'h07
`define OFS_YEAR 8'h08
`define OFS_MIN_MATCH 8'h09
`define OFS_HOUR_MATCH 8'h0A
`define OFS_DAY_MATCH 8'h0B
`define OFS_WDAY_MATCH 8'h0C

// ****************************************
// field positions
// ****************************************
`define BIT_MATCH_OFF 7
`define BIT_CENTURY 7
`define BIT_ALARM_FLAG 3
`define BIT_IRQ_ALLOW 1
`define MONTH_MSB 4
`define MIN_MSB 6
`define HOUR_MSB 5
`define DAY_MSB 5
`define WDAY_MSB 2

// ****************************************
// reset values and calendar limits
// ****************************************
`define RST_DAY 8'h01
`define RST_MONTH 8'h01
`define RST_YEAR 8'h00
`define RST_MATCH 8'h80
`define FIRST_DAY 8'h01
`define FIRST_MONTH 8'h01
`define LAST_MONTH 8'h12
`define FIRST_YEAR 8'h00
`define LAST_YEAR 8'h99
`define DAYS_28 8'h28
`define DAYS_29 8'h29
`define DAYS_30 8'h30
`define DAYS_31 8'h31
`define MON_FEB 8'h02
`define MON_APR 8'h04
`define MON_JUN 8'h06
`define MON_SEP 8'h09
`define MON_NOV 8'h11

`endif

// *** bcd2_count.v ***
// two-digit bcd counter with load, programmable first and last value
// assumes single clock, synchronous active-low reset, one step per cycle
`default_nettype none
`timescale 1ns/100ps

module bcd2_count #(
  parameter [7:0] RST_VAL = 8'h00
) (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_step,
  input wire i_load,
  input wire [7:0] i_load_val,
  input wire [7:0] i_first,
  input wire [7:0] i_last,
  output wire [7:0] o_val,
  output wire o_wrap
);

  reg [7:0] val_q;
  reg [7:0] val_d;
  wire [7:0] inc_val;

  assign o_val = val_q;
  assign o_wrap = i_step && !i_load && (val_q >= i_last);
  assign inc_val = (val_q[3:0] == 4'h9) ? {val_q[7:4] + 4'h1, 4'h0}
                                        : {val_q[7:4], val_q[3:0] + 4'h1};

  always @* begin
    val_d = val_q;
    if (i_load) begin
      val_d = i_load_val;
    end else if (o_wrap) begin
      val_d = i_first;
    end else if (i_step) begin
      val_d = inc_val;
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      val_q <= RST_VAL;
    end else begin
      val_q <= val_d;
    end
  end

endmodule
`default_nettype wire

// *** cal_alarm_monitor.sv ***
// port checker for the calendar and alarm access unit
// assumes a bind onto calendar_alarm_access_unit, one clock domain
`timescale 1ns/100ps
`default_nettype none
module cal_alarm_monitor (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_tick_1hz,
  input wire logic i_acc_active,
  input wire logic i_wr_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_day_carry,
  input wire logic [6:0] i_cur_minute,
  input wire logic [5:0] i_cur_hour,
  input wire logic [2:0] i_cur_weekday,
  input wire logic [7:0] o_rdata,
  input wire logic o_count_step,
  input wire logic o_int_n
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic allow_wr;
  assign allow_wr = i_wr_en && i_addr == 8'h01 && i_wdata[1];
  // ********
  // sequences
  // ********
  sequence s_held_tick;
    i_tick_1hz && i_acc_active ##1 i_acc_active [*4];
  endsequence
  sequence s_match_wr;
    i_wr_en && i_addr == 8'h09 ##1 i_addr == 8'h09;
  endsequence
  // ********
  // properties
  // ********
  a_step_after_tick: assert property (i_tick_1hz && !i_acc_active |=> o_count_step)
    else $error("tick gave no step");
  a_frozen_no_step: assert property ($past(i_acc_active) |-> !o_count_step)
    else $error("step while frozen");
  a_step_one_cycle: assert property (o_count_step && !$past(i_acc_active, 2) |=> !o_count_step)
    else $error("step longer than one cycle");
  a_release_step: assert property (s_held_tick ##1 !i_acc_active |=> o_count_step)
    else $error("pending tick lost");
  a_int_cause: assert property ($fell(o_int_n) |-> $past(o_count_step, 4) || $past(allow_wr, 2))
    else $error("interrupt without cause");
  a_month_unused: assert property ($past(i_addr) == 8'h07 |-> o_rdata[6:5] == 2'h0)
    else $error("month unused bits set");
  a_match_unused: assert property (($past(i_addr) == 8'h0A || $past(i_addr) == 8'h0B) |-> !o_rdata[6])
    else $error("match unused bit set");
  a_wday_unused: assert property ($past(i_addr) == 8'h0C |-> o_rdata[6:3] == 4'h0)
    else $error("weekday unused bits set");
  a_match_write: assert property (s_match_wr |=> o_rdata == $past(i_wdata, 2))
    else $error("minute match readback");
  a_year_bcd: assert property ($past(i_addr) == 8'h08 |-> o_rdata[7:4] <= 4'h9 && o_rdata[3:0] <= 4'h9)
    else $error("year not bcd");
endmodule
bind calendar_alarm_access_unit cal_alarm_monitor i_mon (.i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n), .i_tick_1hz(i_tick_1hz), .i_acc_active(i_acc_active), .i_wr_en(i_wr_en),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_day_carry(i_day_carry), .i_cur_minute(i_cur_minute),
  .i_cur_hour(i_cur_hour), .i_cur_weekday(i_cur_weekday), .o_rdata(o_rdata),
  .o_count_step(o_count_step), .o_int_n(o_int_n));
`default_nettype wire

// *** lower_count_model.sv ***
// behavioural lower time counters answering a step with a day carry
// assumes the unit's step pulse and one clock
`timescale 1ns/100ps
`default_nettype none
module lower_count_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_step,
  input wire logic i_wrap,
  output logic o_day_carry
);
  // carry one cycle after a step, only when the hour is told to wrap
  always @(posedge i_clk_sys) begin
    o_day_carry <= i_rst_n & i_step & i_wrap;
  end
endmodule
`default_nettype wire

// *** calendar_alarm_access_unit_tb.sv ***
// testbench: register rows, calendar roll, freeze and alarm cases
// assumes 100 MHz clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module calendar_alarm_access_unit_tb;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q;} row_t;
  row_t rows [0:7] = '{'{8'h07, 8'h72, 8'h12}, '{8'h08, 8'h99, 8'h99},
    '{8'h09, 8'hD9, 8'hD9}, '{8'h0A, 8'hE3, 8'hA3}, '{8'h0B, 8'hF1, 8'hB1},
    '{8'h0C, 8'hFE, 8'h86}, '{8'h02, 8'hFF, 8'h00}, '{8'h10, 8'hFF, 8'h00}};
  logic i_clk_sys, i_rst_n, i_tick_1hz, i_acc_active, i_wr_en, i_day_carry, wrap;
  logic o_count_step, o_int_n;
  logic [7:0] i_addr, i_wdata, o_rdata, s0;
  logic [7:0] n_step = 8'h00;
  logic [6:0] i_cur_minute;
  logic [5:0] i_cur_hour;
  logic [2:0] i_cur_weekday;
  int num_errors, n_compared;
  calendar_alarm_access_unit i_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_tick_1hz(i_tick_1hz), .i_acc_active(i_acc_active), .i_wr_en(i_wr_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_day_carry(i_day_carry),
    .i_cur_minute(i_cur_minute), .i_cur_hour(i_cur_hour), .i_cur_weekday(i_cur_weekday),
    .o_rdata(o_rdata), .o_count_step(o_count_step), .o_int_n(o_int_n));
  lower_count_model i_low (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_step(o_count_step), .i_wrap(wrap), .o_day_carry(i_day_carry));
  // ********
  // tasks
  // ********
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t byte %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t bit %b exp %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    cyc(1);
    i_wr_en <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] q);
    i_addr <= a;
    cyc(1);
    @(negedge i_clk_sys);
    chk8(o_rdata, q);
    cyc(1);
  endtask
  task automatic tick();
    i_tick_1hz <= 1'b1;
    cyc(1);
    i_tick_1hz <= 1'b0;
    cyc(8);
  endtask
  task automatic cal(input logic [7:0] y, input logic [7:0] m, input logic [7:0] d);
    wr(8'h08, y);
    wr(8'h07, m);
    wr(8'h05, d);
    tick();
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ********
  // clock, counters, watchdog
  // ********
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) if (o_count_step === 1'b1) n_step <= n_step + 8'h01;
  initial begin
    #50000;
    num_errors++;
    report_and_stop();
  end
  // ********
  // main sequence
  // ********
  initial begin
    i_rst_n = 1'b0;
    i_tick_1hz = 1'b0;
    i_acc_active = 1'b0;
    i_wr_en = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    wrap = 1'b0;
    i_cur_minute = 7'h30;
    i_cur_hour = 6'h12;
    i_cur_weekday = 3'h3;
    cyc(10);
    i_rst_n <= 1'b1;
    chk1(o_int_n, 1'b1);
    rd(8'h05, 8'h01);
    rd(8'h07, 8'h01);
    rd(8'h08, 8'h00);
    rd(8'h01, 8'h00);
    for (int i = 9; i < 13; i++) rd(i[7:0], 8'h80);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].q);
    end
    // calendar roll through year end, leap and plain february
    wrap <= 1'b1;
    cal(8'h99, 8'h12, 8'h31);
    rd(8'h05, 8'h01);
    rd(8'h07, 8'h81);
    rd(8'h08, 8'h00);
    cal(8'h00, 8'h02, 8'h28);
    rd(8'h05, 8'h29);
    tick();
    rd(8'h05, 8'h01);
    rd(8'h07, 8'h03);
    cal(8'h01, 8'h02, 8'h28);
    rd(8'h05, 8'h01);
    wrap <= 1'b0;
    // two ticks inside one short access give a single step
    s0 = n_step;
    i_acc_active <= 1'b1;
    i_tick_1hz <= 1'b1;
    cyc(1);
    i_tick_1hz <= 1'b0;
    cyc(2);
    i_tick_1hz <= 1'b1;
    cyc(1);
    i_tick_1hz <= 1'b0;
    cyc(1);
    chk8(n_step - s0, 8'h00);
    i_acc_active <= 1'b0;
    cyc(6);
    chk8(n_step - s0, 8'h01);
    // seven bytes from the seconds pointer in one access
    i_acc_active <= 1'b1;
    for (int a = 2; a < 9; a++) begin
      rd(a[7:0], (a == 5 || a == 8) ? 8'h01 : (a == 7) ? 8'h03 : 8'h00);
    end
    i_acc_active <= 1'b0;
    // alarm on minute only, sticky flag, and-write, no enables
    wr(8'h09, 8'h30);
    wr(8'h01, 8'h02);
    tick();
    chk1(o_int_n, 1'b0);
    rd(8'h01, 8'h0A);
    wr(8'h01, 8'h02);
    tick();
    rd(8'h01, 8'h02);
    chk1(o_int_n, 1'b1);
    i_cur_minute <= 7'h31;
    tick();
    i_cur_minute <= 7'h30;
    tick();
    rd(8'h01, 8'h0A);
    wr(8'h01, 8'h0A);
    rd(8'h01, 8'h0A);
    wr(8'h01, 8'h08);
    rd(8'h01, 8'h08);
    chk1(o_int_n, 1'b1);
    wr(8'h01, 8'h00);
    wr(8'h09, 8'hB0);
    i_cur_minute <= 7'h31;
    tick();
    i_cur_minute <= 7'h30;
    tick();
    rd(8'h01, 8'h00);
    // hour, day and weekday together, then a reset in mid-run
    wr(8'h0A, 8'h12);
    wr(8'h0B, 8'h01);
    wr(8'h0C, 8'h03);
    wr(8'h01, 8'h02);
    i_cur_weekday <= 3'h4;
    tick();
    rd(8'h01, 8'h02);
    i_cur_weekday <= 3'h3;
    tick();
    rd(8'h01, 8'h0A);
    chk1(o_int_n, 1'b0);
    i_rst_n <= 1'b0;
    cyc(2);
    i_rst_n <= 1'b1;
    chk1(o_int_n, 1'b1);
    rd(8'h01, 8'h00);
    rd(8'h0A, 8'h80);
    rd(8'h05, 8'h01);
    report_and_stop();
  end
endmodule
`default_nettype wire
